// file: bench/ext_irq_and_vector_logic_tb.sv
module ext_irq_and_vector_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rstn_i = 0, gie = 0, serve = 0, ext_q = 1, ext_p, taken, irq, wake;
  logic [11:0] pc_q = 12'hFFF, pc_p;
  logic [12:0] per_q = 0;
  logic [15:0] vec;
  logic [16:0] vack;
  logic [31:0] rd;
  ext_irq_pkg::wb_req_type wb_q = '0;
  ext_irq_pkg::wb_rsp_type wb_r;
  int fails = 0, cmp_count = 0, p;
  ext_irq_and_vector_logic dut (.clk_i(clk_i), .rstn_i(rstn_i), .wb_i(wb_q), .wb_o(wb_r),
    .ext_req_pin_i(ext_p), .pin_change_inputs_i(pc_p), .periph_req_i(per_q), .global_ie_i(gie),
    .vec_taken_i(taken), .irq_req_o(irq), .vector_o(vec), .vec_ack_o(vack), .wake_o(wake));
  pin_core_model partner (.clk_i(clk_i), .rstn_i(rstn_i), .serve_i(serve), .ext_lvl_i(ext_q),
    .pc_lvl_i(pc_q), .irq_req_i(irq), .ext_req_pin_o(ext_p), .pin_change_inputs_o(pc_p),
    .vec_taken_o(taken));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  task automatic cyc(int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(logic we, logic [7:0] a, logic [7:0] d);
    int t;
    t = 0;
    wb_q <= '{1'b1, 1'b1, we, a, 4'hF, {24'h0, d}};
    @(posedge clk_i);
    while (wb_r.ack !== 1'b1 && t < 50) begin
      @(posedge clk_i);
      t++;
    end
    if (wb_r.ack !== 1'b1) fails++;
    rd = wb_r.dat;
    wb_q <= '0;
    @(posedge clk_i);
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (e !== g) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] flag_exp(int m, logic rise);
    return (m == 1 || m == (rise ? 3 : 2)) ? 8'h40 : 8'h00;
  endfunction
  function automatic logic [15:0] low_vec(logic [12:0] r);
    for (int i = 0; i < 13; i++) if (r[i]) return 16'h0004 + 16'(i);
    return 16'h0000;
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #80000;
    fails++;
    give_verdict();
  end
  initial begin
    void'($urandom(89));
    cyc(8);
    rstn_i <= 1;
    cyc(4);
    chk("vector", 16'h0000, vec);
    for (int i = 0; i < 7; i++) begin
      wb(0, 8'(4 * i), 0);
      chk("reg", i == 5 ? 32'h1FFF0000 : 32'h00000000, rd);
    end
    gie <= 1;
    for (int k = 0; k < 21; k++) begin
      per_q <= k < 13 ? 13'(1) << k : 13'($urandom_range(8191, 1));
      cyc(4);
      chk("vector", low_vec(per_q), vec);
    end
    per_q <= 0;
    gie <= 0;
    wb(1, ext_irq_pkg::ENABLE_OFS, 8'h40);
    for (int m = 1; m < 4; m++) begin
      wb(1, ext_irq_pkg::CTRL_OFS, 8'(m));
      wb(1, ext_irq_pkg::FLAG_OFS, 8'hFF);
      ext_q <= 0;
      cyc(6);
      wb(0, ext_irq_pkg::FLAG_OFS, 0);
      chk("ext flag fall", flag_exp(m, 0), rd & 8'h70);
      chk("irq", 0, irq);
      wb(1, ext_irq_pkg::FLAG_OFS, 8'hFF);
      ext_q <= 1;
      cyc(6);
      wb(0, ext_irq_pkg::FLAG_OFS, 0);
      chk("ext flag rise", flag_exp(m, 1), rd & 8'h70);
    end
    wb(1, ext_irq_pkg::CTRL_OFS, 0);
    wb(1, ext_irq_pkg::FLAG_OFS, 8'hFF);
    gie <= 1;
    ext_q <= 0;
    cyc(6);
    chk("level irq", 1, irq);
    chk("vector", 16'h0001, vec);
    chk("level wake", 1, wake);
    chk("level ack", 17'h00002, vack);
    wb(0, ext_irq_pkg::FLAG_OFS, 0);
    chk("level flag", 0, rd & 8'h40);
    ext_q <= 1;
    wb(1, ext_irq_pkg::ENABLE_OFS, 8'h30);
    for (int k = 0; k < 6; k++) begin
      p = k < 2 ? 11 * k : $urandom_range(11, 0);
      rd = $urandom & ~(32'h1 << p);
      wb(1, ext_irq_pkg::MASK_LO_OFS, rd[7:0]);
      wb(1, ext_irq_pkg::MASK_HI_OFS, rd[11:8]);
      wb(1, ext_irq_pkg::FLAG_OFS, 8'hFF);
      pc_q[p] <= ~pc_q[p];
      cyc(6);
      wb(0, ext_irq_pkg::FLAG_OFS, 0);
      chk("masked pin", 0, rd & 8'h70);
      wb(1, p < 8 ? ext_irq_pkg::MASK_LO_OFS : ext_irq_pkg::MASK_HI_OFS, 8'h1 << (p % 8));
      pc_q[p] <= ~pc_q[p];
      cyc(6);
      wb(0, ext_irq_pkg::FLAG_OFS, 0);
      chk("pc flag", p < 8 ? 8'h10 : 8'h20, rd & 8'h70);
      chk("vector", p < 8 ? 16'h0002 : 16'h0003, vec);
      chk("pc ack", p < 8 ? 17'h00004 : 17'h00008, vack);
      serve <= 1;
      cyc(6);
      serve <= 0;
      wb(0, ext_irq_pkg::FLAG_OFS, 0);
      chk("served flag", 0, rd & 8'h70);
      chk("served irq", 0, irq);
    end
    per_q <= 13'h0010;
    cyc(4);
    chk("vector", 16'h0008, vec);
    rstn_i <= 0;
    cyc(2);
    chk("reset vector", 16'h0000, vec);
    chk("reset irq", 0, irq);
    rstn_i <= 1;
    cyc(4);
    wb(0, ext_irq_pkg::MASK_LO_OFS, 0);
    chk("mask after reset", 0, rd);
    give_verdict();
  end
endmodule

// file: bench/pin_core_model.sv
module pin_core_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic serve_i,
  input wire logic ext_lvl_i,
  input wire logic [11:0] pc_lvl_i,
  input wire logic irq_req_i,
  output logic ext_req_pin_o,
  output logic [11:0] pin_change_inputs_o,
  output logic vec_taken_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins change only on the clock, so every level lasts a full cycle or more
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_req_pin_o <= 1'b1;
      pin_change_inputs_o <= 12'hFFF;
      vec_taken_o <= 1'b0;
    end else begin
      ext_req_pin_o <= ext_lvl_i;
      pin_change_inputs_o <= pc_lvl_i;
      vec_taken_o <= serve_i && irq_req_i && !vec_taken_o;
    end
  end
endmodule

// file: logic/ext_irq_and_vector_logic.sv
// How it works
// - after any reset the fetch address is 0x0000
// - external request vectors to 0x0001, pin-change low 0x0002, high 0x0003
// - watchdog 0x0004, 16-bit timer capture, compa, compb, overflow 0x0005-0x0008
// - 8-bit timer 0x0009-0x000B, comparator, adc, eeprom, serial start, overflow 0x000C-0x0010
// - pins trigger requests even when driven as outputs by the device
// - any enabled toggle on inputs 7..0 raises the low pin-change group
// - any enabled toggle on inputs 11..8 raises the high pin-change group
// - per-pin masks select contributing pins; masked toggles are ignored
// - pin-change wake comes from the same clocked toggle detection that sets the flags
// - external pin triggers on falling, rising or low level by sense bits
// - level mode keeps the request asserted while the pin stays low
// - edge detection runs only on the clock
// - low level raises wake from deep sleep
// - level wake needs the low held through start-up, else no interrupt
// - sense 00 low, 01 any change, 10 falling, 11 rising
// - pin sampled before edge detection; pulses over one clock caught
// - flags set on event, clear on vector or written one; level mode clear
// - request taken only with global and own enable; else stays pending
module ext_irq_and_vector_logic (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire ext_irq_pkg::wb_req_type wb_i,
  output ext_irq_pkg::wb_rsp_type wb_o,
  input wire logic ext_req_pin_i,
  input wire logic [11:0] pin_change_inputs_i,
  input wire logic [ext_irq_pkg::PERIPH_COUNT-1:0] periph_req_i,
  input wire logic global_ie_i,
  input wire logic vec_taken_i,
  output logic irq_req_o,
  output logic [15:0] vector_o,
  output logic [ext_irq_pkg::VEC_COUNT-1:0] vec_ack_o,
  output logic wake_o
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [12:0] pin_s1_q;
  logic [12:0] pin_s2_q;
  logic [12:0] pin_s3_q;
  logic [7:0] ctrl_q;
  logic [7:0] enable_q;
  logic [7:0] mask_lo_q;
  logic [7:0] mask_hi_q;
  logic ext_flag_q;
  logic pc_lo_flag_q;
  logic pc_hi_flag_q;
  ext_irq_pkg::wb_rsp_type wb_q;
  logic irq_req_q;
  logic [15:0] vector_q;
  logic [ext_irq_pkg::VEC_COUNT-1:0] vec_ack_q;
  logic wake_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // pins are sampled even when driven by the device itself
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 13'h1FFF;
      pin_s2_q <= 13'h1FFF;
      pin_s3_q <= 13'h1FFF;
    end else begin
      pin_s1_q <= {ext_req_pin_i, pin_change_inputs_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  wire logic ext_now = pin_s2_q[12];
  wire logic ext_prev = pin_s3_q[12];
  wire logic [1:0] sense = {ctrl_q[ext_irq_pkg::SENSE_HI_POS], ctrl_q[ext_irq_pkg::SENSE_LO_POS]};
  wire logic level_mode = (sense == ext_irq_pkg::SENSE_LOW);
  wire logic [11:0] pc_toggle = pin_s2_q[11:0] ^ pin_s3_q[11:0];
  wire logic pc_lo_event = |(pc_toggle[7:0] & mask_lo_q);
  wire logic pc_hi_event = |(pc_toggle[11:8] & mask_hi_q[3:0]);
  wire logic ext_event =
    (sense == ext_irq_pkg::SENSE_ANY && (ext_now ^ ext_prev)) ||
    (sense == ext_irq_pkg::SENSE_FALL && ext_prev && !ext_now) ||
    (sense == ext_irq_pkg::SENSE_RISE && !ext_prev && ext_now);
  wire logic ext_level_req = level_mode && !ext_now;

  // wishbone decode
  wire logic wb_hit = wb_i.cyc && wb_i.stb && !wb_q.ack;
  wire logic wb_wr = wb_hit && wb_i.we && wb_i.sel[0];
  wire logic wr_ctrl = wb_wr && wb_i.adr == ext_irq_pkg::CTRL_OFS;
  wire logic wr_enable = wb_wr && wb_i.adr == ext_irq_pkg::ENABLE_OFS;
  wire logic wr_flag = wb_wr && wb_i.adr == ext_irq_pkg::FLAG_OFS;
  wire logic wr_mask_lo = wb_wr && wb_i.adr == ext_irq_pkg::MASK_LO_OFS;
  wire logic wr_mask_hi = wb_wr && wb_i.adr == ext_irq_pkg::MASK_HI_OFS;
  wire logic [7:0] wdat = wb_i.dat[7:0];

  // requests in vector order, index equals vector address
  wire logic ext_en = enable_q[ext_irq_pkg::EXT_BIT_POS];
  wire logic pc_lo_en = enable_q[ext_irq_pkg::PC_LO_BIT_POS];
  wire logic pc_hi_en = enable_q[ext_irq_pkg::PC_HI_BIT_POS];
  wire logic [ext_irq_pkg::VEC_COUNT-1:0] pending = {periph_req_i,
    pc_hi_flag_q && pc_hi_en, pc_lo_flag_q && pc_lo_en,
    (ext_flag_q || ext_level_req) && ext_en, 1'b0};
  wire logic [ext_irq_pkg::VEC_COUNT-1:0] taken_mask = pending & {ext_irq_pkg::VEC_COUNT{global_ie_i}};
  wire logic [ext_irq_pkg::VEC_COUNT-1:0] winner = taken_mask & (~taken_mask + 17'h00001);
  logic [15:0] winner_vec;
  always_comb begin
    winner_vec = ext_irq_pkg::VEC_RESET;
    for (int i = ext_irq_pkg::VEC_COUNT - 1; i > 0; i--) begin
      if (taken_mask[i]) begin
        winner_vec = 16'(i);
      end
    end
  end
  wire logic [ext_irq_pkg::VEC_COUNT-1:0] exec = vec_taken_i ? vec_ack_q : '0;
  wire logic wake_d = |(pc_toggle & {mask_hi_q[3:0], mask_lo_q}) || (ext_level_req && ext_en);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= ext_irq_pkg::CTRL_RESET;
      enable_q <= ext_irq_pkg::ENABLE_RESET;
      mask_lo_q <= ext_irq_pkg::MASK_RESET;
      mask_hi_q <= ext_irq_pkg::MASK_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wdat;
      end
      if (wr_enable) begin
        enable_q <= wdat & 8'h70;
      end
      if (wr_mask_lo) begin
        mask_lo_q <= wdat;
      end
      if (wr_mask_hi) begin
        mask_hi_q <= wdat & 8'h0F;
      end
    end
  end

  // flags: a set in the same cycle as a clear wins
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ext_flag_q <= 1'b0;
      pc_lo_flag_q <= 1'b0;
      pc_hi_flag_q <= 1'b0;
    end else begin
      ext_flag_q <= !level_mode && (ext_event ||
        (ext_flag_q && !(wr_flag && wdat[ext_irq_pkg::EXT_BIT_POS]) && !exec[1]));
      pc_lo_flag_q <= pc_lo_event ||
        (pc_lo_flag_q && !(wr_flag && wdat[ext_irq_pkg::PC_LO_BIT_POS]) && !exec[2]);
      pc_hi_flag_q <= pc_hi_event ||
        (pc_hi_flag_q && !(wr_flag && wdat[ext_irq_pkg::PC_HI_BIT_POS]) && !exec[3]);
    end
  end

  // vector output; reset holds the fetch address at zero
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_req_q <= 1'b0;
      vector_q <= ext_irq_pkg::VEC_RESET;
      vec_ack_q <= '0;
      wake_q <= 1'b0;
    end else begin
      irq_req_q <= |taken_mask && !vec_taken_i;
      vector_q <= winner_vec;
      vec_ack_q <= vec_taken_i ? '0 : winner;
      wake_q <= wake_d;
    end
  end

  wire logic [31:0] rd_data =
    (wb_i.adr == ext_irq_pkg::CTRL_OFS) ? {24'h000000, ctrl_q} :
    (wb_i.adr == ext_irq_pkg::ENABLE_OFS) ? {24'h000000, enable_q} :
    (wb_i.adr == ext_irq_pkg::FLAG_OFS) ? {24'h000000, 1'b0, ext_flag_q, pc_hi_flag_q, pc_lo_flag_q, 4'h0} :
    (wb_i.adr == ext_irq_pkg::MASK_LO_OFS) ? {24'h000000, mask_lo_q} :
    (wb_i.adr == ext_irq_pkg::MASK_HI_OFS) ? {24'h000000, mask_hi_q} :
    (wb_i.adr == ext_irq_pkg::STATUS_OFS) ? {3'h0, pin_s2_q, vector_q} : 32'h00000000;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wb_q <= '0;
    end else begin
      wb_q.ack <= wb_hit;
      wb_q.dat <= wb_hit ? rd_data : 32'h00000000;
    end
  end

  assign wb_o = wb_q;
  assign irq_req_o = irq_req_q;
  assign vector_o = vector_q;
  assign vec_ack_o = vec_ack_q;
  assign wake_o = wake_q;

  // checks
  sequence fall_seen_s;
    sense == ext_irq_pkg::SENSE_FALL && ext_prev && !ext_now;
  endsequence

  sequence rise_seen_s;
    sense == ext_irq_pkg::SENSE_RISE && !ext_prev && ext_now;
  endsequence

  sequence any_seen_s;
    sense == ext_irq_pkg::SENSE_ANY && ext_prev != ext_now;
  endsequence

  sequence flag_write_s;
    wr_flag && wdat[ext_irq_pkg::PC_LO_BIT_POS] && !pc_lo_event;
  endsequence

  // the core executes the low group vector while no new toggle arrives
  sequence served_lo_s;
    vec_taken_i && vec_ack_o[2] && !pc_lo_event;
  endsequence

  // vector selection: lowest pending address wins
  reset_vector_a: assert property (@(posedge clk_i) !rst_n |=> vector_o == ext_irq_pkg::VEC_RESET)
    else $error("vector not zero after reset");

  idle_vector_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    taken_mask == '0 |=> vector_o == ext_irq_pkg::VEC_RESET)
    else $error("vector not zero with nothing pending");

  ext_vector_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    global_ie_i && ext_en && (ext_flag_q || ext_level_req) |=> vector_o == ext_irq_pkg::VEC_EXT)
    else $error("external request not on its vector");

  pc_lo_vector_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    global_ie_i && pending[2:1] == 2'h2 |=> vector_o == ext_irq_pkg::VEC_PC_LO)
    else $error("low pin-change group not on its vector");

  pc_hi_vector_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    global_ie_i && pending[3:1] == 3'h4 |=> vector_o == ext_irq_pkg::VEC_PC_HI)
    else $error("high pin-change group not on its vector");

  periph_vector_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    global_ie_i && pending[3:0] == 4'h0 && periph_req_i[0] |=> vector_o == ext_irq_pkg::VEC_WATCHDOG)
    else $error("watchdog vector wrong");

  serial_vector_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    global_ie_i && pending[15:0] == 16'h0000 && periph_req_i[12] |=> vector_o == ext_irq_pkg::VEC_SERIAL_OVF)
    else $error("serial overflow vector wrong");

  // pin-change groups
  pc_lo_set_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    pc_toggle[0] && mask_lo_q[0] |=> pc_lo_flag_q)
    else $error("low group toggle missed");

  pc_hi_set_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    pc_toggle[8] && mask_hi_q[0] |=> pc_hi_flag_q)
    else $error("high group toggle missed");

  mask_block_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    !pc_lo_flag_q && pc_toggle[7:0] != 8'h00 && (pc_toggle[7:0] & mask_lo_q) == 8'h00 |=> !pc_lo_flag_q)
    else $error("masked toggle set the flag");

  mask_hi_block_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    !pc_hi_flag_q && pc_toggle[11:8] != 4'h0 && (pc_toggle[11:8] & mask_hi_q[3:0]) == 4'h0 |=> !pc_hi_flag_q)
    else $error("masked toggle set the high group flag");

  // external request pin
  fall_edge_a: assert property (@(posedge clk_i) disable iff (!rst_n) fall_seen_s |=> ext_flag_q)
    else $error("falling edge missed");

  rise_edge_a: assert property (@(posedge clk_i) disable iff (!rst_n) rise_seen_s |=> ext_flag_q)
    else $error("rising edge missed");

  any_edge_a: assert property (@(posedge clk_i) disable iff (!rst_n) any_seen_s |=> ext_flag_q)
    else $error("change on the external request missed");

  quiet_fall_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    sense == ext_irq_pkg::SENSE_FALL && !ext_flag_q && !(ext_prev && !ext_now) |=> !ext_flag_q)
    else $error("external flag set without a falling edge");

  level_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    level_mode && !ext_now && ext_en && global_ie_i && !vec_taken_i |=> irq_req_o && !ext_flag_q)
    else $error("level request not held");

  level_noflag_a: assert property (@(posedge clk_i) disable iff (!rst_n) level_mode |=> !ext_flag_q)
    else $error("external flag set in level mode");

  // clearing, gating and wake-up
  flag_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n) flag_write_s |=> !pc_lo_flag_q)
    else $error("written one did not clear flag");

  served_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n) served_lo_s |=> !pc_lo_flag_q)
    else $error("executed vector did not clear flag");

  gate_off_a: assert property (@(posedge clk_i) disable iff (!rst_n) !global_ie_i |=> !irq_req_o)
    else $error("request taken while disabled");

  taken_drop_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    vec_taken_i |=> !irq_req_o && vec_ack_o == '0)
    else $error("request still shown after the vector was taken");

  wake_pin_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    pc_toggle[0] && mask_lo_q[0] |=> wake_o)
    else $error("pin change did not wake");

  level_wake_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    ext_level_req && ext_en |=> wake_o)
    else $error("low level did not wake");
endmodule

// file: logic/ext_irq_pkg.sv
package ext_irq_pkg;
  // register byte addresses on the wishbone port
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ENABLE_OFS = 8'h04;
  localparam logic [7:0] FLAG_OFS = 8'h08;
  localparam logic [7:0] MASK_LO_OFS = 8'h0C;
  localparam logic [7:0] MASK_HI_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  // field positions
  localparam int SENSE_LO_POS = 0;
  localparam int SENSE_HI_POS = 1;
  localparam int EXT_BIT_POS = 6;
  localparam int PC_HI_BIT_POS = 5;
  localparam int PC_LO_BIT_POS = 4;
  localparam int PC_LO_WIDTH = 8;
  localparam int PC_HI_WIDTH = 4;
  localparam int PERIPH_COUNT = 13;
  localparam int VEC_COUNT = 17;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // sense encodings
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;
  // vector addresses
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_EXT = 16'h0001;
  localparam logic [15:0] VEC_PC_LO = 16'h0002;
  localparam logic [15:0] VEC_PC_HI = 16'h0003;
  localparam logic [15:0] VEC_WATCHDOG = 16'h0004;
  localparam logic [15:0] VEC_T16_CAPT = 16'h0005;
  localparam logic [15:0] VEC_T16_OVF = 16'h0008;
  localparam logic [15:0] VEC_T8_COMPA = 16'h0009;
  localparam logic [15:0] VEC_COMPARATOR = 16'h000C;
  localparam logic [15:0] VEC_SERIAL_OVF = 16'h0010;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_type;
endpackage
